// *** verilog/rx_fifo_request_flush_ctrl.sv ***
// receive fifo with request threshold, interrupt enable and flush
`timescale 1ns/1ns
// Contract
// - with the enable set, the serial port interrupt is high whenever the request flag is set.
// - with the enable clear, the request flag never raises the serial port interrupt.
// - writing one to the flush control resets the fifo counters and drops stored bytes.
// - the flush control returns to zero by itself after one system clock cycle.
// - the request flag is set when the stored byte count exceeds the 2-bit threshold.
module rx_fifo_request_flush_ctrl (
   input  wire logic                     pclk,        // system clock
   input  wire logic                     presetn,     // async reset, low
   input  wire rx_fifo_pkg::apb_req_type apb_req,     // apb request
   output logic [31:0]                   prdata,      // apb read data
   output logic                          pready,      // apb ready
   output logic                          pslverr,     // apb error
   input  wire rx_fifo_pkg::rx_in_type   rx_in,       // received byte
   output logic [2:0]                    rx_count,    // stored bytes
   output logic                          rx_request_flag, // request
   output logic                          serial_irq,  // port interrupt
   output logic                          irq          // status interrupt
);
   localparam int unsigned DEPTH = rx_fifo_pkg::DEPTH;

   logic [1:0]                       thresh_r, thresh_nxt;
   logic                             ien_r, ien_nxt;
   logic                             flush_r, flush_nxt;
   logic [rx_fifo_pkg::EV_W-1:0]     stat_r, stat_nxt;
   logic [rx_fifo_pkg::EV_W-1:0]     mask_r, mask_nxt;
   logic [7:0]                       mem_r [DEPTH];
   logic [7:0]                       mem_nxt [DEPTH];
   logic [1:0]                       wptr_r, wptr_nxt;
   logic [1:0]                       rptr_r, rptr_nxt;
   logic [2:0]                       cnt_r, cnt_nxt;
   logic                             flag_r, flag_nxt;
   logic [31:0]                      prdata_r, prdata_nxt;
   logic                             setup, access, wr, rd, mapped;
   logic                             push, pop, ovr;
   logic [rx_fifo_pkg::EV_W-1:0]     ev;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign setup  = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign wr     = access & apb_req.pwrite;
   assign rd     = access & ~apb_req.pwrite;
   assign mapped = hit(apb_req.paddr, rx_fifo_pkg::OFF_CTRL)
                 | hit(apb_req.paddr, rx_fifo_pkg::OFF_STATUS)
                 | hit(apb_req.paddr, rx_fifo_pkg::OFF_DATA)
                 | hit(apb_req.paddr, rx_fifo_pkg::OFF_INT_STAT)
                 | hit(apb_req.paddr, rx_fifo_pkg::OFF_INT_MASK);
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata  = prdata_r;

   // fifo traffic; nothing moves during the flush cycle
   assign pop  = rd & hit(apb_req.paddr, rx_fifo_pkg::OFF_DATA)
               & (cnt_r != 3'h0) & ~flush_r;
   assign push = rx_in.push & ~flush_r
               & ((cnt_r != 3'(DEPTH)) | pop);
   assign ovr  = rx_in.push & ~flush_r & (cnt_r == 3'(DEPTH)) & ~pop;

   // control group: threshold, enable, mask and the flush strobe
   always_comb begin
      thresh_nxt = thresh_r;
      ien_nxt    = ien_r;
      mask_nxt   = mask_r;
      flush_nxt  = 1'b0;
      if (wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_CTRL)) begin
         thresh_nxt = apb_req.pwdata[rx_fifo_pkg::CTRL_TH_LSB +: 2];
         ien_nxt    = apb_req.pwdata[rx_fifo_pkg::CTRL_IEN];
         flush_nxt  = apb_req.pwdata[rx_fifo_pkg::CTRL_FLUSH];
      end
      if (wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_INT_MASK)) begin
         mask_nxt = apb_req.pwdata[rx_fifo_pkg::EV_W-1:0];
      end
   end

   // fifo group: storage, pointers, count and request flag
   always_comb begin
      wptr_nxt   = wptr_r;
      rptr_nxt   = rptr_r;
      mem_nxt    = mem_r;
      if (push) begin
         mem_nxt[wptr_r] = rx_in.data;
         wptr_nxt        = wptr_r + 2'h1;
      end
      if (pop) begin
         rptr_nxt = rptr_r + 2'h1;
      end
      cnt_nxt = 3'(cnt_r + {2'h0, push} - {2'h0, pop});
      if (flush_r) begin
         wptr_nxt = 2'h0;
         rptr_nxt = 2'h0;
         cnt_nxt  = 3'h0;
      end
      flag_nxt = cnt_nxt > {1'b0, thresh_nxt};
   end

   always_comb begin
      ev                         = '0;
      ev[rx_fifo_pkg::EV_REQ]    = flag_nxt & ~flag_r;
      ev[rx_fifo_pkg::EV_OVR]    = ovr;
      ev[rx_fifo_pkg::EV_FLUSH]  = flush_r;
      stat_nxt = stat_r;
      if (wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_INT_STAT)) begin
         stat_nxt = stat_r & ~apb_req.pwdata[rx_fifo_pkg::EV_W-1:0];
      end
      // a new event wins over a clear
      stat_nxt = stat_nxt | ev;
   end

   always_comb begin
      prdata_nxt = prdata_r;
      if (setup) begin
         prdata_nxt = 32'h0000_0000;
         case (apb_req.paddr)
            rx_fifo_pkg::OFF_CTRL: begin
               prdata_nxt[rx_fifo_pkg::CTRL_TH_LSB +: 2] = thresh_r;
               prdata_nxt[rx_fifo_pkg::CTRL_IEN]         = ien_r;
               prdata_nxt[rx_fifo_pkg::CTRL_FLUSH]       = flush_r;
            end
            rx_fifo_pkg::OFF_STATUS: begin
               prdata_nxt[rx_fifo_pkg::STAT_CNT_LSB +: 3] = cnt_r;
               prdata_nxt[rx_fifo_pkg::STAT_FLAG]         = flag_r;
            end
            rx_fifo_pkg::OFF_DATA: begin
               if (cnt_r != 3'h0) begin
                  prdata_nxt[7:0] = mem_r[rptr_r];
               end
            end
            rx_fifo_pkg::OFF_INT_STAT: begin
               prdata_nxt[rx_fifo_pkg::EV_W-1:0] = stat_r;
            end
            rx_fifo_pkg::OFF_INT_MASK: begin
               prdata_nxt[rx_fifo_pkg::EV_W-1:0] = mask_r;
            end
            default: begin
               prdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // control group registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thresh_r <= rx_fifo_pkg::RST_THRESH;
         ien_r    <= rx_fifo_pkg::RST_IEN;
         flush_r  <= 1'b0;
         mask_r   <= rx_fifo_pkg::RST_MASK;
      end else begin
         thresh_r <= thresh_nxt;
         ien_r    <= ien_nxt;
         flush_r  <= flush_nxt;
         mask_r   <= mask_nxt;
      end
   end

   // fifo group registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_r   <= 2'h0;
         rptr_r   <= 2'h0;
         cnt_r    <= 3'h0;
         flag_r   <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= 8'h00;
         end
      end else begin
         wptr_r   <= wptr_nxt;
         rptr_r   <= rptr_nxt;
         cnt_r    <= cnt_nxt;
         flag_r   <= flag_nxt;
         mem_r    <= mem_nxt;
      end
   end

   // sticky event status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r   <= '0;
      end else begin
         stat_r   <= stat_nxt;
      end
   end

   // read data, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   assign rx_count        = cnt_r;
   assign rx_request_flag = flag_r;
   assign serial_irq      = ien_r & flag_r;
   assign irq             = |(stat_r & mask_r);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_irq_follows_flag: assert property (
      ien_r && flag_r |-> serial_irq)
      else $error("serial interrupt missing while flag and enable set");
   a_irq_gated_off: assert property (
      !ien_r |-> !serial_irq)
      else $error("serial interrupt raised while enable clear");
   a_flush_empties: assert property (
      wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_CTRL)
         && apb_req.pwdata[rx_fifo_pkg::CTRL_FLUSH]
      |=> flush_r ##1 (cnt_r == 3'h0 && wptr_r == 2'h0
                       && rptr_r == 2'h0))
      else $error("flush did not empty the fifo");
   a_flush_selfclear: assert property (
      $rose(flush_r) |=> !flush_r)
      else $error("flush control stayed set beyond one cycle");
   a_flag_threshold: assert property (
      $changed(cnt_r) && cnt_r > {1'b0, thresh_r} |-> flag_r)
      else $error("request flag not set above threshold");
   a_flag_clears: assert property (
      flush_r |=> !flag_r && !rx_request_flag)
      else $error("request flag still set after flush");
   a_count_bound: assert property (
      cnt_r <= 3'(DEPTH))
      else $error("fifo count beyond depth");
   a_event_sticky: assert property (
      ovr |=> stat_r[rx_fifo_pkg::EV_OVR])
      else $error("overrun event not recorded");

   // request flag against count and threshold
   a_flag_matches: assert property (
      cnt_r > {1'b0, thresh_r} |-> flag_r)
      else $error("request flag low above threshold");
   a_flag_at_limit: assert property (
      cnt_r <= {1'b0, thresh_r} |-> !flag_r)
      else $error("request flag high at or below threshold");

   // fifo bookkeeping
   a_flush_zero: assert property (
      flush_r |=> cnt_r == 3'h0)
      else $error("bytes kept across a flush");
   a_push_counts: assert property (
      push && !pop && !flush_r
      |=> cnt_r == $past(cnt_r) + 3'h1)
      else $error("push did not raise the count");
   a_pop_counts: assert property (
      pop && !push && !flush_r
      |=> cnt_r == $past(cnt_r) - 3'h1)
      else $error("pop did not lower the count");
   a_full_holds: assert property (
      ovr |=> cnt_r == 3'(DEPTH))
      else $error("overrun changed the count");

   // register bus
   a_prdata_stands: assert property (
      !setup |=> prdata == $past(prdata))
      else $error("read data changed outside setup");
   a_slverr_access: assert property (
      pslverr |-> access)
      else $error("error flagged outside access phase");
   a_thresh_holds: assert property (
      !(wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_CTRL))
      |=> thresh_r == $past(thresh_r))
      else $error("threshold changed without a write");
   a_ien_holds: assert property (
      !(wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_CTRL))
      |=> ien_r == $past(ien_r))
      else $error("enable changed without a write");
   a_mask_holds: assert property (
      !(wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_INT_MASK))
      |=> mask_r == $past(mask_r))
      else $error("mask changed without a write");

   // interrupt status
   a_req_event: assert property (
      $rose(flag_r) |-> stat_r[rx_fifo_pkg::EV_REQ])
      else $error("flag rise not recorded");
   a_flush_event: assert property (
      flush_r |=> stat_r[rx_fifo_pkg::EV_FLUSH])
      else $error("flush event not recorded");
   a_stat_clear: assert property (
      wr && hit(apb_req.paddr, rx_fifo_pkg::OFF_INT_STAT)
         && apb_req.pwdata[rx_fifo_pkg::EV_OVR] && !ovr
      |=> !stat_r[rx_fifo_pkg::EV_OVR])
      else $error("overrun status not cleared by write");
   a_mask_quiet: assert property (
      mask_r == '0 |-> !irq)
      else $error("status interrupt raised with mask clear");
   a_irq_on_ovr: assert property (
      stat_r[rx_fifo_pkg::EV_OVR] && mask_r[rx_fifo_pkg::EV_OVR] |-> irq)
      else $error("status interrupt missing for overrun");

   c_flush: cover property (flush_r ##1 cnt_r == 3'h0);
   c_flag_irq: cover property (!serial_irq ##1 serial_irq);
   c_fill: cover property (cnt_r == 3'(DEPTH) ##1 ovr);
   c_flag_cleared: cover property (flag_r && flush_r ##1 !flag_r);
   c_bad_addr: cover property (pslverr);
endmodule

// *** verilog/rx_fifo_pkg.sv ***
// shared constants and types for the receive fifo control slice
package rx_fifo_pkg;
   localparam int unsigned DEPTH      = 4;
   localparam int unsigned CNT_W      = 3;
   localparam int unsigned ADDR_W     = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_DATA     = 8'h08;
   localparam logic [7:0] OFF_INT_STAT = 8'h0C;
   localparam logic [7:0] OFF_INT_MASK = 8'h10;
   // control field positions
   localparam int unsigned CTRL_TH_LSB = 0;
   localparam int unsigned CTRL_IEN    = 2;
   localparam int unsigned CTRL_FLUSH  = 3;
   // status field positions
   localparam int unsigned STAT_CNT_LSB = 0;
   localparam int unsigned STAT_FLAG    = 3;
   // interrupt event bit positions
   localparam int unsigned EV_REQ   = 0;
   localparam int unsigned EV_OVR   = 1;
   localparam int unsigned EV_FLUSH = 2;
   localparam int unsigned EV_W     = 3;
   // reset values
   localparam logic [1:0]      RST_THRESH = 2'h0;
   localparam logic            RST_IEN    = 1'b0;
   localparam logic [EV_W-1:0] RST_MASK   = 3'h0;
   // flush lasts one system clock cycle
   localparam int unsigned FLUSH_CYCLES = 1;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [7:0] data;
      logic       push;
   } rx_in_type;
endpackage

// *** bench/rx_fifo_request_flush_ctrl_tb.sv ***
// self-checking bench for the receive fifo control slice
`timescale 1ns/1ns
module rx_fifo_request_flush_ctrl_tb;
   logic                     pclk;
   logic                     presetn;
   rx_fifo_pkg::apb_req_type apb_req;
   rx_fifo_pkg::rx_in_type   rx_in;
   logic [31:0]              prdata;
   logic                     pready;
   logic                     pslverr;
   logic [2:0]               rx_count;
   logic                     rx_request_flag;
   logic                     serial_irq;
   logic                     irq;
   logic [31:0]              rd;
   logic                     err;
   int                       failures;
   int                       tests_run;

   rx_fifo_request_flush_ctrl uut (
      .pclk            (pclk),
      .presetn         (presetn),
      .apb_req         (apb_req),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .rx_in           (rx_in),
      .rx_count        (rx_count),
      .rx_request_flag (rx_request_flag),
      .serial_irq      (serial_irq),
      .irq             (irq)
   );

   always #50 pclk = ~pclk;

   task automatic summarize();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; read data and error land in rd and err
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      if (pready !== 1'b1) begin
         failures++;
         summarize();
      end
   endtask

   task automatic push(input logic [7:0] d);
      @(posedge pclk);
      rx_in <= '{d, 1'b1};
      @(posedge pclk);
      rx_in.push <= 1'b0;
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      apb_req = '0;
      rx_in = '0;
      failures = 0;
      tests_run = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, rx_fifo_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, rx_fifo_pkg::OFF_INT_MASK, 32'h0);
      chk(rd, 32'h0);
      for (int th = 0; th < 4; th++) begin
         apb(1'b1, rx_fifo_pkg::OFF_CTRL, 32'(th));
         for (int i = 0; i <= th; i++) begin
            apb(1'b0, rx_fifo_pkg::OFF_STATUS, 32'h0);
            chk(rd, 32'(i));
            push(8'(8'hA0 + i));
         end
         apb(1'b0, rx_fifo_pkg::OFF_STATUS, 32'h0);
         chk(rd, 32'(th + 1) | 32'h8);
         @(negedge pclk);
         chk({31'h0, rx_request_flag}, 32'h1);
         chk({31'h0, serial_irq}, 32'h0);
         apb(1'b1, rx_fifo_pkg::OFF_CTRL, 32'(th) | 32'h4);
         @(negedge pclk);
         chk({31'h0, serial_irq}, 32'h1);
         apb(1'b0, rx_fifo_pkg::OFF_DATA, 32'h0);
         chk(rd, 32'hA0);
         apb(1'b0, rx_fifo_pkg::OFF_STATUS, 32'h0);
         chk(rd, 32'(th));
         apb(1'b1, rx_fifo_pkg::OFF_CTRL, 32'(th) | 32'hC);
         repeat (2) @(negedge pclk);
         chk({29'h0, rx_count}, 32'h0);
         chk({31'h0, rx_request_flag}, 32'h0);
         apb(1'b0, rx_fifo_pkg::OFF_CTRL, 32'h0);
         chk(rd, 32'(th) | 32'h4);
         apb(1'b0, rx_fifo_pkg::OFF_DATA, 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, rx_fifo_pkg::OFF_INT_STAT, 32'h0);
      chk(rd, 32'h5);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, rx_fifo_pkg::OFF_INT_MASK, 32'h7);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, rx_fifo_pkg::OFF_INT_STAT, 32'h7);
      apb(1'b0, rx_fifo_pkg::OFF_INT_STAT, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // overrun: five bytes into a four-deep fifo
      for (int i = 0; i < 5; i++) push(8'(i));
      apb(1'b0, rx_fifo_pkg::OFF_INT_STAT, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, rx_fifo_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'hC);
      chk({31'h0, rx_request_flag}, 32'h1);
      chk({31'h0, serial_irq}, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      summarize();
   end
endmodule
